// ==== include/bsc_pkg.sv ====
// shared constants for the burst-of-four command and byte-write block
package bsc_pkg;
    localparam int DATA_W_DEF  = 36;
    localparam int LANE_W      = 9;
    localparam int ADDR_W_DEF  = 21;
    localparam int SYNC_STAGES = 3;
    localparam int BURST_LEN   = 4;
    localparam int BEAT_W      = 2;
    localparam int WR_LEAD_K   = 2;
    localparam int BUF_DEPTH   = 2;
    localparam logic [1:0] LEAD_CNT_RST = 2'h0;
    localparam logic [1:0] BEAT_FIRST   = 2'h0;
    localparam logic [1:0] BEAT_LAST    = 2'h3;

    typedef enum logic [3:0] {
        BSC_WR_IDLE  = 4'h1,
        BSC_WR_BEAT1 = 4'h2,
        BSC_WR_BEAT2 = 4'h4,
        BSC_WR_BEAT3 = 4'h8
    } bsc_wr_state_t;
endpackage

// ==== src/bsc_buf2.sv ====
// two-entry valid/ready buffer for write beats
`timescale 1ns/1ns
module bsc_buf2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    logic [WIDTH-1:0] mem_r [bsc_pkg::BUF_DEPTH];
    logic             wr_ptr_r;
    logic             rd_ptr_r;
    logic [1:0]       count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            case ({push, pop})
                2'b10:   count_r <= count_r + 2'h1;
                2'b01:   count_r <= count_r - 2'h1;
                default: count_r <= count_r;
            endcase
        end
    end
endmodule // bsc_buf2

// ==== src/bsc_cmd_wr.sv ====
// command acceptance, burst read sequencing and byte-masked burst write capture
`timescale 1ns/1ns
// Functional notes
// [R1] A read burst starts when read select is seen low at a positive input clock rise.
// [R2] A write burst starts when write select is seen low at a positive input clock rise.
// [R3] The controller finishes every pending burst before it stops the input clocks.
// [R4] The controller spaces commands of one type at least two positive clock rises apart.
// [R5] A command on the rise right after an accepted command of the same type is dropped.
// [R6] With both selects low on the first rise after an idle rise, only the read is done.
// [R7] The controller holds write select low at the command rise even for a fully masked burst.
// [R8] In the 18-bit build, mask 0 gates bits 0-8 and mask 1 gates bits 9-17, low enables.
// [R9] In the 36-bit build, masks 0-3 gate lanes 0-8, 9-17, 18-26 and 27-35, low enables.
// [R10] Four beats and masks are taken on K, K#, K, K# rises from t+2.0 through t+3.5.
// [R11] Masks apply per beat; a beat with every mask high changes nothing.
// [R12] Only lanes unmasked at a beat's own edge are written; other beats stay unaffected.
// [R13] Burst addresses run linearly through base plus 0, 1, 2 and 3.
// [R14] Read and write sequencers run independently and may overlap.
module bsc_cmd_wr #(
    parameter int DATA_W = bsc_pkg::DATA_W_DEF,
    parameter int ADDR_W = bsc_pkg::ADDR_W_DEF,
    parameter int LANES  = DATA_W / bsc_pkg::LANE_W
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    // pins from the memory controller
    input  wire logic              k_clk_i,
    input  wire logic              k_clk_n_i,
    input  wire logic              read_sel_n_i,
    input  wire logic              write_sel_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic [LANES-1:0]  byte_mask_n_i,
    // read beats to the output path
    output logic                   rd_beat_valid_o,
    output logic [ADDR_W-1:0]      rd_beat_addr_o,
    output logic                   rd_busy_o,
    // write beats to the array
    output logic                   wr_valid_o,
    input  wire logic              wr_ready_i,
    output logic [ADDR_W-1:0]      wr_addr_o,
    output logic [DATA_W-1:0]      wr_data_o,
    output logic [LANES-1:0]       wr_lane_en_o,
    // status
    output logic                   wr_busy_o,
    output logic                   wr_overrun_o
);
    localparam int PIN_W = 4 + ADDR_W + DATA_W + LANES;
    localparam int BUF_W = ADDR_W + DATA_W + LANES;

    // pin synchronisers: three stages, change counts when stages two and three agree
    logic [PIN_W-1:0] s1_r;
    logic [PIN_W-1:0] s2_r;
    logic [PIN_W-1:0] s3_r;
    logic             k_lvl_r;
    logic             kn_lvl_r;
    logic             k_rise;
    logic             kn_rise;
    logic             rsel_n;
    logic             wsel_n;
    logic [ADDR_W-1:0] pin_addr;
    logic [DATA_W-1:0] pin_data;
    logic [LANES-1:0]  pin_mask_n;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end else begin
            s1_r <= {k_clk_i, k_clk_n_i, read_sel_n_i, write_sel_n_i,
                     addr_i, data_i, byte_mask_n_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign {rsel_n, wsel_n, pin_addr, pin_data, pin_mask_n} = s3_r[PIN_W-3:0];
    assign k_rise  = s2_r[PIN_W-1] && s3_r[PIN_W-1] && !k_lvl_r;
    assign kn_rise = s2_r[PIN_W-2] && s3_r[PIN_W-2] && !kn_lvl_r;

    // clock levels only move once both late stages agree, so a glitch is one edge at most
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            k_lvl_r  <= 1'b1;
            kn_lvl_r <= 1'b1;
        end else begin
            if (s2_r[PIN_W-1] == s3_r[PIN_W-1]) begin
                k_lvl_r <= s3_r[PIN_W-1];
            end
            if (s2_r[PIN_W-2] == s3_r[PIN_W-2]) begin
                kn_lvl_r <= s3_r[PIN_W-2];
            end
        end
    end

    // command decode at each positive clock rise
    logic prev_rd_r;
    logic prev_wr_r;
    logic prev_nop_r;
    logic rd_acc;
    logic wr_acc;

    // [R1] read start, [R5] drops back-to-back
    assign rd_acc = k_rise && !rsel_n && !prev_rd_r;
    // [R2] write start, [R5] back-to-back drop, [R6] read wins after idle
    assign wr_acc = k_rise && !wsel_n && !prev_wr_r && !(prev_nop_r && !rsel_n);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            prev_rd_r  <= 1'b0;
            prev_wr_r  <= 1'b0;
            prev_nop_r <= 1'b1;
        end else if (k_rise) begin
            prev_rd_r  <= rd_acc;
            prev_wr_r  <= wr_acc;
            prev_nop_r <= rsel_n && wsel_n;
        end
    end

    // read sequencer: four beats on K, K#, K, K# starting at the command rise
    logic [ADDR_W-1:0] rd_base_r;
    logic [1:0]        rd_beat_r;
    logic              rd_act_r;
    logic              rd_step;

    assign rd_step = rd_act_r && (rd_beat_r[0] ? k_rise : kn_rise);

    // [R14] read side runs apart from the write side
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rd_base_r       <= '0;
            rd_beat_r       <= bsc_pkg::BEAT_FIRST;
            rd_act_r        <= 1'b0;
            rd_beat_valid_o <= 1'b0;
            rd_beat_addr_o  <= '0;
        end else begin
            rd_beat_valid_o <= rd_acc || rd_step;
            if (rd_acc) begin
                rd_base_r      <= pin_addr;
                rd_beat_r      <= bsc_pkg::BEAT_FIRST;
                rd_act_r       <= 1'b1;
                rd_beat_addr_o <= pin_addr;
            end else if (rd_step) begin
                rd_beat_r      <= rd_beat_r + 2'h1;
                rd_act_r       <= (rd_beat_r + 2'h1) != bsc_pkg::BEAT_LAST;
                // [R13] linear burst address
                rd_beat_addr_o <= rd_base_r + ADDR_W'(rd_beat_r + 2'h1);
            end
        end
    end
    assign rd_busy_o = rd_act_r;

    // write sequencer: pending slot waits for the second K rise after the command
    logic [ADDR_W-1:0]      pend_addr_r;
    logic                   pend_v_r;
    logic [1:0]             pend_k_r;
    logic                   pend_go;
    logic [ADDR_W-1:0]      wr_base_r;
    logic [1:0]             wr_beat_r;
    bsc_pkg::bsc_wr_state_t wr_state_r;
    logic                   cap;

    // [R10] beat zero lands on the K rise at t+2.0
    assign pend_go = pend_v_r && k_rise && (pend_k_r == 2'(bsc_pkg::WR_LEAD_K - 1));

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pend_addr_r <= '0;
            pend_v_r    <= 1'b0;
            pend_k_r    <= bsc_pkg::LEAD_CNT_RST;
        end else if (wr_acc) begin
            pend_addr_r <= pin_addr;
            pend_v_r    <= 1'b1;
            pend_k_r    <= bsc_pkg::LEAD_CNT_RST;
        end else if (pend_go) begin
            pend_v_r <= 1'b0;
        end else if (pend_v_r && k_rise) begin
            pend_k_r <= pend_k_r + 2'h1;
        end
    end

    // [R10] alternate K and K# rises for beats one to three
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wr_state_r <= bsc_pkg::BSC_WR_IDLE;
            wr_base_r  <= '0;
            wr_beat_r  <= bsc_pkg::BEAT_FIRST;
        end else if (pend_go) begin
            wr_state_r <= bsc_pkg::BSC_WR_BEAT1;
            wr_base_r  <= pend_addr_r;
        end else begin
            case (wr_state_r)
                bsc_pkg::BSC_WR_IDLE:  wr_state_r <= bsc_pkg::BSC_WR_IDLE;
                bsc_pkg::BSC_WR_BEAT1: if (kn_rise) wr_state_r <= bsc_pkg::BSC_WR_BEAT2;
                bsc_pkg::BSC_WR_BEAT2: if (k_rise)  wr_state_r <= bsc_pkg::BSC_WR_BEAT3;
                bsc_pkg::BSC_WR_BEAT3: if (kn_rise) wr_state_r <= bsc_pkg::BSC_WR_IDLE;
                default:               wr_state_r <= bsc_pkg::BSC_WR_IDLE;
            endcase
        end
        if (resetn_i && (pend_go || cap)) begin
            wr_beat_r <= pend_go ? 2'h1 : wr_beat_r + 2'h1;
        end
    end

    always_comb begin
        case (wr_state_r)
            bsc_pkg::BSC_WR_BEAT1: cap = kn_rise;
            bsc_pkg::BSC_WR_BEAT2: cap = k_rise;
            bsc_pkg::BSC_WR_BEAT3: cap = kn_rise;
            default:               cap = 1'b0;
        endcase
    end
    assign wr_busy_o = pend_v_r || (wr_state_r != bsc_pkg::BSC_WR_IDLE);

    // beat assembly: address, lane enables and lane data
    logic [ADDR_W-1:0] beat_addr;
    logic [LANES-1:0]  lane_en;
    logic [DATA_W-1:0] lane_data;
    logic              beat_push;
    logic              buf_in_ready;
    logic [BUF_W-1:0]  buf_out;

    // [R13] base plus beat index
    assign beat_addr = pend_go ? pend_addr_r : wr_base_r + ADDR_W'(wr_beat_r);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // [R8] [R9] low mask enables its nine-bit lane
            assign lane_en[g] = !pin_mask_n[g];
            // [R12] masked lane data is dropped, it is don't-care
            assign lane_data[g*bsc_pkg::LANE_W +: bsc_pkg::LANE_W] =
                lane_en[g] ? pin_data[g*bsc_pkg::LANE_W +: bsc_pkg::LANE_W] : '0;
        end
    endgenerate

    // [R11] an all-masked beat never reaches the array
    assign beat_push = (pend_go || cap) && (lane_en != '0);

    // pins cannot be stalled, so a refused beat is flagged rather than waited for
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wr_overrun_o <= 1'b0;
        end else if (beat_push && !buf_in_ready) begin
            wr_overrun_o <= 1'b1;
        end
    end

    bsc_buf2 #(
        .WIDTH (BUF_W)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (beat_push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({beat_addr, lane_data, lane_en}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (buf_out)
    );
    assign {wr_addr_o, wr_data_o, wr_lane_en_o} = buf_out;
endmodule // bsc_cmd_wr

// ==== tb/bsc_cmd_wr_asserts.sv ====
// checker for the command and byte-write block
`timescale 1ns/1ns
module bsc_cmd_wr_asserts #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 21,
    parameter int LANES  = 4
) (
    // clock and reset
    input wire logic              clk_sys_i,
    input wire logic              resetn_i,
    // read side
    input wire logic              rd_beat_valid_o,
    input wire logic [ADDR_W-1:0] rd_beat_addr_o,
    input wire logic              rd_busy_o,
    // write side
    input wire logic              wr_valid_o,
    input wire logic              wr_ready_i,
    input wire logic [DATA_W-1:0] wr_data_o,
    input wire logic [LANES-1:0]  wr_lane_en_o,
    input wire logic              wr_overrun_o
);
    logic [1:0]        cnt_r;
    logic [ADDR_W-1:0] prev_r;
    logic [DATA_W-1:0] lane_en;
    for (genvar i = 0; i < DATA_W; i++) begin : g_l
        assign lane_en[i] = wr_lane_en_o[i / bsc_pkg::LANE_W];
    end
    // beats counted here, a range of repetitions would be needed otherwise
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_r <= 2'h0;
            prev_r <= '0;
        end else if (rd_beat_valid_o) begin
            cnt_r <= rd_busy_o ? cnt_r + 2'h1 : 2'h0;
            prev_r <= rd_beat_addr_o;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    rd_start_a: assert property ($rose(rd_busy_o) |-> rd_beat_valid_o && cnt_r == 2'h0)
        else $error("read burst began without a beat");
    rd_four_a: assert property (rd_beat_valid_o && !rd_busy_o |-> cnt_r == 2'h3)
        else $error("read burst not four beats");
    rd_step_a: assert property (rd_beat_valid_o && cnt_r != 2'h0 |->
        rd_beat_addr_o == ADDR_W'(prev_r + 1'b1))
        else $error("read beat address not linear");
    rd_pulse_a: assert property (rd_beat_valid_o |=> !rd_beat_valid_o [*2])
        else $error("read beats too close");
    wr_nonempty_a: assert property (wr_valid_o |-> |wr_lane_en_o)
        else $error("fully masked beat pushed");
    wr_masked_a: assert property (wr_valid_o |-> !(|(wr_data_o & ~lane_en)))
        else $error("masked lane carries data");
    wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_data_o) && $stable(wr_lane_en_o))
        else $error("stalled beat changed");
    wr_sticky_a: assert property (wr_overrun_o |=> wr_overrun_o)
        else $error("overrun flag cleared");
endmodule // bsc_cmd_wr_asserts

bind bsc_cmd_wr bsc_cmd_wr_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES))
    bsc_cmd_wr_asserts_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .rd_beat_valid_o(rd_beat_valid_o), .rd_beat_addr_o(rd_beat_addr_o),
    .rd_busy_o(rd_busy_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_data_o(wr_data_o), .wr_lane_en_o(wr_lane_en_o), .wr_overrun_o(wr_overrun_o));

// ==== tb/bsc_ctrl_model.sv ====
// controller model: input clock pair and pin levels per half period
`timescale 1ns/1ns
module bsc_ctrl_model (
    // clock and levels for the next half period
    input  wire logic        clk_sys_i,
    input  wire logic [62:0] next_i,
    // phase and pins
    output logic [3:0]       phase_o,
    output logic             k_clk_o,
    output logic             k_clk_n_o,
    output logic [62:0]      pins_o
);
    initial begin
        phase_o = 4'h0;
        k_clk_o = 1'b1;
        k_clk_n_o = 1'b0;
        pins_o = '1;
    end
    // clock pair runs free, no burst is cut short by a stop
    always @(posedge clk_sys_i) begin
        phase_o <= (phase_o == 4'hB) ? 4'h0 : phase_o + 4'h1;
        if (phase_o == 4'hB || phase_o == 4'h5) begin
            k_clk_o <= !k_clk_o;
            k_clk_n_o <= k_clk_o;
        end
        // pins move three cycles clear of each clock edge
        if (phase_o == 4'h2 || phase_o == 4'h8) begin
            pins_o <= next_i;
        end
    end
endmodule // bsc_ctrl_model

// ==== tb/testbench.sv ====
// self-checking bench for the command and byte-write block
`timescale 1ns/1ns
module testbench;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wr_ready_i = 1'b0;
    logic stall = 1'b0;
    logic [62:0] nxt = '1;
    logic [62:0] pins;
    logic [3:0] ph, wl;
    logic k, kn, rbv, rbusy, wv, wbusy, wovr;
    logic [20:0] rba, wa;
    logic [35:0] wd;
    logic [20:0] rq[$];
    logic [60:0] wq[$];
    logic [87:0] wh = '0;
    logic rp = 1'b0, wp = 1'b0, ip = 1'b1, lr = 1'b1, lw = 1'b1;
    logic wv8;
    logic [20:0] wa8;
    logic [17:0] wd8;
    logic [1:0] wl8;
    logic [40:0] wq8[$];
    logic [15:0] mt[3] = '{16'hEDB7, 16'h0F5A, 16'hFFFF};
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 17950;
    always #50 clk_sys_i = !clk_sys_i;
    bsc_ctrl_model bsc_ctrl_model_i (.clk_sys_i(clk_sys_i), .next_i(nxt), .phase_o(ph),
        .k_clk_o(k), .k_clk_n_o(kn), .pins_o(pins));
    bsc_cmd_wr #(.DATA_W(36), .ADDR_W(21)) bsc_cmd_wr_i (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .k_clk_i(k), .k_clk_n_i(kn), .read_sel_n_i(pins[62]),
        .write_sel_n_i(pins[61]), .addr_i(pins[60:40]), .data_i(pins[39:4]),
        .byte_mask_n_i(pins[3:0]), .rd_beat_valid_o(rbv), .rd_beat_addr_o(rba),
        .rd_busy_o(rbusy), .wr_valid_o(wv), .wr_ready_i(wr_ready_i), .wr_addr_o(wa),
        .wr_data_o(wd), .wr_lane_en_o(wl), .wr_busy_o(wbusy), .wr_overrun_o(wovr));
    // narrow build on the low lanes of the same pins
    bsc_cmd_wr #(.DATA_W(18), .ADDR_W(21)) bsc_cmd_wr_n18_i (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .k_clk_i(k), .k_clk_n_i(kn), .read_sel_n_i(pins[62]),
        .write_sel_n_i(pins[61]), .addr_i(pins[60:40]), .data_i(pins[21:4]),
        .byte_mask_n_i(pins[1:0]), .rd_beat_valid_o(), .rd_beat_addr_o(),
        .rd_busy_o(), .wr_valid_o(wv8), .wr_ready_i(wr_ready_i), .wr_addr_o(wa8),
        .wr_data_o(wd8), .wr_lane_en_o(wl8), .wr_busy_o(), .wr_overrun_o());
    task automatic chk(input string s, input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask
    function automatic void pw(input logic [20:0] a, input logic [35:0] d,
                               input logic [3:0] m);
        for (int i = 0; i < 36; i++) d[i] = d[i] & !m[i / 9];
        if (m != 4'hF) wq.push_back({a, d, ~m});
        if (m[1:0] != 2'h3) wq8.push_back({a, d[17:0], ~m[1:0]});
    endfunction
    // one input clock cycle: selects at the rise, masks m0 and m1 for its two beats
    task automatic kc(input logic r, input logic w, input logic [3:0] m0, m1);
        logic [20:0] a;
        logic [35:0] d0, d1;
        logic ra, wa2;
        a = 21'($random(seed));
        d0 = {$random(seed), 4'($random(seed))};
        d1 = {$random(seed), 4'($random(seed))};
        ra = !r && !rp;
        // both selects after an idle rise keep the read only
        wa2 = !w && !wp && (r || !ip);
        rp = ra;
        wp = wa2;
        ip = r && w;
        lr = r;
        lw = w;
        // read beats at base plus 0 to 3
        for (int i = 0; i < 4; i++) if (ra) rq.push_back(a + 21'(i));
        wh = {wh[65:0], wa2, a};
        // beats 0 and 2 at the rise, 1 and 3 at the complement rise
        if (wh[65]) pw(wh[64:44], d0, m0);
        if (wh[87]) pw(wh[86:66] + 21'h2, d0, m0);
        @(posedge clk_sys_i iff ph == 4'h7);
        nxt <= {r, w, a, d0, m0};
        if (wh[65]) pw(wh[64:44] + 21'h1, d1, m1);
        if (wh[87]) pw(wh[86:66] + 21'h3, d1, m1);
        @(posedge clk_sys_i iff ph == 4'h1);
        nxt <= {2'h3, ~a, d1, m1};
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        if (resetn_i && rbv === 1'b1) begin
            if (rq.size() == 0) chk("spare read", 64'h1, 64'h0);
            else chk("read addr", rba, rq.pop_front());
        end
        if (resetn_i && wv === 1'b1 && wr_ready_i === 1'b1) begin
            if (wq.size() == 0) chk("spare write", 64'h1, 64'h0);
            else chk("write beat", {wa, wd, wl}, wq.pop_front());
        end
        if (resetn_i && wv8 === 1'b1 && wr_ready_i === 1'b1) begin
            if (wq8.size() == 0) chk("spare narrow write", 64'h1, 64'h0);
            else chk("narrow beat", {wa8, wd8, wl8}, wq8.pop_front());
        end
        wr_ready_i <= !stall && ($random(seed) % 4 != 0);
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) kc(1, 1, 4'h0, 4'h0);
        // second read on the next rise is dropped
        kc(0, 1, 4'h0, 4'h0);
        kc(0, 1, 4'h0, 4'h0);
        kc(1, 1, 4'h0, 4'h0);
        $display("test reads done");
        // each lane, all, none; select low for a fully masked burst
        foreach (mt[j]) begin
            kc(1, 0, 4'h0, 4'h0);
            kc(1, 1, 4'h0, 4'h0);
            kc(1, 1, mt[j][15:12], mt[j][11:8]);
            kc(1, 1, mt[j][7:4], mt[j][3:0]);
        end
        $display("test byte masks done");
        // back to back writes, then both selects after idle
        kc(1, 0, 4'h0, 4'h0);
        kc(1, 0, 4'h0, 4'h0);
        repeat (4) kc(1, 1, 4'h0, 4'h0);
        kc(0, 0, 4'h0, 4'h0);
        repeat (4) kc(1, 1, 4'h0, 4'h0);
        $display("test dropped commands done");
        // random traffic never issues one type on two rises in a row; overlap
        repeat (30) kc(!lr | 1'($random(seed)), !lw | 1'($random(seed)),
                       4'($random(seed)), 4'($random(seed)));
        repeat (4) kc(1, 1, 4'h0, 4'h0);
        $display("test random traffic done");
        stall = 1'b1;
        kc(1, 0, 4'h0, 4'h0);
        kc(1, 1, 4'h0, 4'h0);
        chk("write busy", wbusy, 64'h1);
        repeat (3) kc(1, 1, 4'h0, 4'h0);
        chk("overrun", wovr, 64'h1);
        wq = wq[0:1];
        wq8 = wq8[0:1];
        stall = 1'b0;
        repeat (2) kc(1, 1, 4'h0, 4'h0);
        chk("write idle", wbusy, 64'h0);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        chk("overrun after reset", wovr, 64'h0);
        {rp, wp, ip} = 3'h1;
        wh = '0;
        repeat (3) kc(1, 1, 4'h0, 4'h0);
        $display("test overrun done");
        chk("reads left", rq.size(), 64'h0);
        chk("writes left", wq.size(), 64'h0);
        chk("narrow writes left", wq8.size(), 64'h0);
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_mismatch++;
        conclude();
    end
endmodule // testbench
